/* rtl/pfm_regs.vh */
// Purpose: constants for the pin function override mux
// Assumes: flat pin index, port A line n is n, port B line n is 23+n
// Notes:   register offsets are byte addresses on the plain register port
`ifndef PFM_REGS_VH
`define PFM_REGS_VH

// register offsets
`define PFM_OFS_CTRL      8'h00
`define PFM_OFS_OSC       8'h04
`define PFM_OFS_STATUS    8'h08
`define PFM_OFS_PIN_SEL   8'h0c
`define PFM_OFS_PIN_INFO  8'h10

// ctrl fields
`define PFM_CTRL_MAP_BIT  0
`define PFM_CTRL_RST      1'h0

// osc fields
`define PFM_OSC_MAIN_BIT  0
`define PFM_OSC_SLOW_BIT  1
`define PFM_OSC_ALT_BIT   2
`define PFM_OSC_RST       3'h0

// pin select reset
`define PFM_PIN_SEL_RST   6'h00

// owner codes, rising priority
`define PFM_OWN_MUX       3'h0
`define PFM_OWN_TRACE     3'h1
`define PFM_OWN_DOUT      3'h2
`define PFM_OWN_JTAG      3'h3
`define PFM_OWN_OSC       3'h4

// trace slot codes
`define PFM_TS_NONE       4'h0
`define PFM_TS_MDO0       4'h1
`define PFM_TS_MDO1       4'h2
`define PFM_TS_MDO2       4'h3
`define PFM_TS_MDO3       4'h4
`define PFM_TS_MDO4       4'h5
`define PFM_TS_MDO5       4'h6
`define PFM_TS_MCKO       4'h7
`define PFM_TS_MSEO0      4'h8
`define PFM_TS_MSEO1      4'h9
`define PFM_TS_EVTO       4'ha
`define PFM_TS_EVTI       4'hb

// fixed pins
`define PFM_PIN_TCK       6'd0
`define PFM_PIN_TMS       6'd1
`define PFM_PIN_TDO       6'd2
`define PFM_PIN_TDI       6'd3
`define PFM_PIN_DOUT      6'd0
`define PFM_PIN_WAKE      6'd11
`define PFM_PIN_XMAIN_IN  6'd8
`define PFM_PIN_XMAIN_OUT 6'd9
`define PFM_PIN_XSLOW_IN  6'd10
`define PFM_PIN_XSLOW_OUT 6'd12
`define PFM_PIN_XSLOW_IN2 6'd13
`define PFM_PIN_XSLOW_OU2 6'd20

// function letters used by pad features
`define PFM_FN_B          3'd1
`define PFM_FN_C          3'd2
`define PFM_FN_D          3'd3
`define PFM_FN_F          3'd5
`define PFM_FN_G          3'd6

`endif

/* rtl/pfm_sync.v */
// Purpose: two-flop synchroniser for pad level inputs
// Assumes: synchronous active-low reset
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module pfm_sync #(
  parameter       W   = 1,
  parameter [0:0] RST = 1'b1
) (
  input  wire         clock,   // system clock
  input  wire         rst_n,   // sync reset, low
  input  wire [W-1:0] d,       // async level in
  output reg  [W-1:0] q        // synchronised level
);
  reg [W-1:0] meta_r;

  always @(posedge clock) begin
    if (!rst_n) begin
      meta_r <= {W{RST}};
      q      <= {W{RST}};
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule
`default_nettype wire

/* rtl/pfm_mux.v */
// Purpose: per-pin function selection and override for the port pins
// Assumes: flat pin index, port A lines 0..22 then port B lines 0..12
// Notes:   pad outputs registered; owner choice itself is combinational
//
// Function
// - two-wire, 5 V and alert pad features only with two-wire or open-drain pwm
// - each line is general purpose or one of peripheral functions A to H
// - owner priority: mux, trace, debug data out, jtag, oscillators
// - jtag takes port A lines 0..3 as clock, mode, data out, data in
// - enabled trace takes its event, data, clock and start/end pins
// - trace map select picks port A map or port B map; event out fixed
// - crystal pins bypass function mux, placed by oscillator control register
// - reset pin debug data function active only with debug link enabled
// - debug data out pin driven only when enabled and two-pin mode set
// - wake request input always live on its own pin
//
// Decided for this implementation: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "pfm_regs.vh"
module pfm_mux #(
  parameter N = 36
) (
  input  wire           clock,            // 250 MHz system clock
  input  wire           rst_n,            // sync reset, low
  input  wire [7:0]     reg_addr,         // register byte address
  input  wire [31:0]    reg_wdata,        // register write data
  input  wire           reg_wr,           // write strobe
  input  wire           reg_rd,           // read strobe
  output reg  [31:0]    reg_rdata,        // read data, cycle after strobe
  input  wire [N-1:0]   gpio_periph_en,   // 1 selects a peripheral function
  input  wire [3*N-1:0] gpio_func_sel,    // function letter per pin, 0 is A
  input  wire [N-1:0]   gpio_out,         // general purpose output value
  input  wire [N-1:0]   gpio_oe,          // general purpose output enable
  input  wire [8*N-1:0] func_out,         // peripheral output, 8 per pin
  input  wire [8*N-1:0] func_oe,          // peripheral output enable, 8 per pin
  output reg  [N-1:0]   pin_in,           // synchronised pad level
  input  wire           jtag_en,          // jtag port enabled
  input  wire           jtag_tdo,         // jtag data out
  output reg            jtag_tck,         // jtag clock from pad
  output reg            jtag_tms,         // jtag mode from pad
  output reg            jtag_tdi,         // jtag data in from pad
  input  wire           trace_en,         // trace system enabled
  input  wire [5:0]     trace_mdo,        // trace message data
  input  wire           trace_mcko,       // trace message clock
  input  wire [1:0]     trace_mseo,       // trace start/end
  input  wire           trace_evto_n,     // trace event out, low
  output reg            trace_evti_n,     // trace event in, low
  input  wire           link_en,          // single-wire debug enabled
  input  wire           link_two_pin,     // two-pin mode command seen
  input  wire           link_data_out,    // link data toward pads
  input  wire           link_data_oe,     // link drive enable, high
  output reg            link_data_in,     // link data from reset pin
  input  wire           rst_pad_in,       // reset pin level
  output reg            rst_pad_out,      // reset pin drive value
  output reg            rst_pad_oe_n,     // reset pin drive, low
  output reg            ext_reset_n,      // external reset request, low
  output reg            wake_req_n,       // wake request, low
  input  wire [N-1:0]   pad_in,           // pad levels
  output reg  [N-1:0]   pad_out,          // pad drive value
  output reg  [N-1:0]   pad_oe_n,         // pad drive, low
  output reg  [N-1:0]   pad_analog_en,    // crystal analog path
  output reg  [N-1:0]   pad_tw_en,        // two-wire pad feature
  output reg  [N-1:0]   pad_5v_en,        // 5 V tolerance feature
  output reg  [N-1:0]   pad_alert_en      // bus alert feature
);

  ////////////////////////////////////////////////////////////////////////
  // tables

  function [3:0] trace_slot;
    input       map_a;
    input [5:0] pin;
    begin
      trace_slot = `PFM_TS_NONE;
      if (pin == 6'd4) begin
        trace_slot = `PFM_TS_EVTO;
      end else if (map_a) begin
        case (pin)
          6'd5:    trace_slot = `PFM_TS_EVTI;
          6'd10:   trace_slot = `PFM_TS_MDO5;
          6'd18:   trace_slot = `PFM_TS_MDO4;
          6'd17:   trace_slot = `PFM_TS_MDO3;
          6'd16:   trace_slot = `PFM_TS_MDO2;
          6'd15:   trace_slot = `PFM_TS_MDO1;
          6'd14:   trace_slot = `PFM_TS_MDO0;
          6'd6:    trace_slot = `PFM_TS_MCKO;
          6'd7:    trace_slot = `PFM_TS_MSEO1;
          6'd11:   trace_slot = `PFM_TS_MSEO0;
          default: trace_slot = `PFM_TS_NONE;
        endcase
      end else begin
        case (pin)
          6'd31:   trace_slot = `PFM_TS_EVTI;
          6'd23:   trace_slot = `PFM_TS_MDO5;
          6'd27:   trace_slot = `PFM_TS_MDO4;
          6'd28:   trace_slot = `PFM_TS_MDO3;
          6'd26:   trace_slot = `PFM_TS_MDO2;
          6'd25:   trace_slot = `PFM_TS_MDO1;
          6'd32:   trace_slot = `PFM_TS_MDO0;
          6'd24:   trace_slot = `PFM_TS_MCKO;
          6'd34:   trace_slot = `PFM_TS_MSEO1;
          6'd35:   trace_slot = `PFM_TS_MSEO0;
          default: trace_slot = `PFM_TS_NONE;
        endcase
      end
    end
  endfunction

  // two-wire function letter on a capable pin
  function is_tw;
    input [5:0] pin;
    input [2:0] fn;
    begin
      case (pin)
        6'd7:    is_tw = (fn == `PFM_FN_C) || (fn == `PFM_FN_D);
        6'd17:   is_tw = (fn == `PFM_FN_D);
        6'd21:   is_tw = (fn == `PFM_FN_B);
        6'd27:   is_tw = (fn == `PFM_FN_D) || (fn == `PFM_FN_G);
        6'd28:   is_tw = (fn == `PFM_FN_D);
        default: is_tw = 1'b0;
      endcase
    end
  endfunction

  // open-drain pwm letter on a capable pin
  function is_odpwm;
    input [5:0] pin;
    input [2:0] fn;
    begin
      is_odpwm = (fn == `PFM_FN_F) &&
                 ((pin == 6'd21) || (pin == 6'd27) || (pin == 6'd28));
    end
  endfunction

  // pins that carry 5 V tolerance and bus alert
  function is_5v_pin;
    input [5:0] pin;
    begin
      is_5v_pin = (pin == 6'd21) || (pin == 6'd27) || (pin == 6'd28);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // registers

  reg        map_a_r;
  reg        map_a_nxt;
  reg  [2:0] osc_r;
  reg  [2:0] osc_nxt;
  reg  [5:0] pin_sel_r;
  reg  [5:0] pin_sel_nxt;

  wire hit_ctrl = (reg_addr == `PFM_OFS_CTRL);
  wire hit_osc  = (reg_addr == `PFM_OFS_OSC);
  wire hit_psel = (reg_addr == `PFM_OFS_PIN_SEL);

  always @* begin
    map_a_nxt   = map_a_r;
    osc_nxt     = osc_r;
    pin_sel_nxt = pin_sel_r;
    if (reg_wr && hit_ctrl) begin
      map_a_nxt = reg_wdata[`PFM_CTRL_MAP_BIT];
    end
    if (reg_wr && hit_osc) begin
      osc_nxt = reg_wdata[2:0];
    end
    if (reg_wr && hit_psel) begin
      pin_sel_nxt = reg_wdata[5:0];
    end
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      map_a_r   <= `PFM_CTRL_RST;
      osc_r     <= `PFM_OSC_RST;
      pin_sel_r <= `PFM_PIN_SEL_RST;
    end else begin
      map_a_r   <= map_a_nxt;
      osc_r     <= osc_nxt;
      pin_sel_r <= pin_sel_nxt;
    end
  end

  wire osc_main = osc_r[`PFM_OSC_MAIN_BIT];
  wire osc_slow = osc_r[`PFM_OSC_SLOW_BIT];
  wire osc_alt  = osc_r[`PFM_OSC_ALT_BIT];

  ////////////////////////////////////////////////////////////////////////
  // input synchronisers

  wire [N-1:0] pad_sync;
  wire         rst_sync;

  pfm_sync #(.W(N), .RST(1'b1)) u_sync_pad (
    .clock (clock),
    .rst_n (rst_n),
    .d     (pad_in),
    .q     (pad_sync)
  );

  pfm_sync #(.W(1), .RST(1'b1)) u_sync_rst (
    .clock (clock),
    .rst_n (rst_n),
    .d     (rst_pad_in),
    .q     (rst_sync)
  );

  ////////////////////////////////////////////////////////////////////////
  // per-pin ownership and drive

  reg [3*N-1:0] own;
  reg [N-1:0]   out_nxt;
  reg [N-1:0]   oen_nxt;
  reg [N-1:0]   ana_nxt;
  reg [N-1:0]   tw_nxt;
  reg [N-1:0]   v5_nxt;
  reg [N-1:0]   alm_nxt;
  reg           dout_act;
  reg [5:0]     p6;
  reg [2:0]     fn;
  reg [3:0]     ts;
  reg           osc_pin;
  reg           tr_o;
  reg           feat;
  integer       i;

  always @* begin
    own      = {3*N{1'b0}};
    out_nxt  = {N{1'b0}};
    oen_nxt  = {N{1'b1}};
    ana_nxt  = {N{1'b0}};
    tw_nxt   = {N{1'b0}};
    v5_nxt   = {N{1'b0}};
    alm_nxt  = {N{1'b0}};
    p6       = 6'd0;
    fn       = 3'd0;
    ts       = `PFM_TS_NONE;
    osc_pin  = 1'b0;
    tr_o     = 1'b0;
    feat     = 1'b0;
    dout_act = link_en && link_two_pin;
    for (i = 0; i < N; i = i + 1) begin
      p6 = i[5:0];
      fn = gpio_func_sel[3*i +: 3];
      ts = trace_slot(map_a_r, p6);
      osc_pin = (osc_main && (p6 == `PFM_PIN_XMAIN_IN ||
                              p6 == `PFM_PIN_XMAIN_OUT)) ||
                (osc_slow && !osc_alt && (p6 == `PFM_PIN_XSLOW_IN ||
                                          p6 == `PFM_PIN_XSLOW_OUT)) ||
                (osc_slow && osc_alt && (p6 == `PFM_PIN_XSLOW_IN2 ||
                                         p6 == `PFM_PIN_XSLOW_OU2));
      // highest enabled owner wins
      if (osc_pin) begin
        own[3*i +: 3] = `PFM_OWN_OSC;
      end else if (jtag_en && p6 <= `PFM_PIN_TDI) begin
        own[3*i +: 3] = `PFM_OWN_JTAG;
      end else if (dout_act && p6 == `PFM_PIN_DOUT) begin
        own[3*i +: 3] = `PFM_OWN_DOUT;
      end else if (trace_en && ts != `PFM_TS_NONE) begin
        own[3*i +: 3] = `PFM_OWN_TRACE;
      end else begin
        own[3*i +: 3] = `PFM_OWN_MUX;
      end
      case (own[3*i +: 3])
        `PFM_OWN_OSC: begin
          ana_nxt[i] = 1'b1;
        end
        `PFM_OWN_JTAG: begin
          out_nxt[i] = jtag_tdo;
          oen_nxt[i] = (p6 != `PFM_PIN_TDO);
        end
        `PFM_OWN_DOUT: begin
          out_nxt[i] = link_data_out;
          oen_nxt[i] = !link_data_oe;
        end
        `PFM_OWN_TRACE: begin
          case (ts)
            `PFM_TS_MDO0:  tr_o = trace_mdo[0];
            `PFM_TS_MDO1:  tr_o = trace_mdo[1];
            `PFM_TS_MDO2:  tr_o = trace_mdo[2];
            `PFM_TS_MDO3:  tr_o = trace_mdo[3];
            `PFM_TS_MDO4:  tr_o = trace_mdo[4];
            `PFM_TS_MDO5:  tr_o = trace_mdo[5];
            `PFM_TS_MCKO:  tr_o = trace_mcko;
            `PFM_TS_MSEO0: tr_o = trace_mseo[0];
            `PFM_TS_MSEO1: tr_o = trace_mseo[1];
            `PFM_TS_EVTO:  tr_o = trace_evto_n;
            default:       tr_o = 1'b0;
          endcase
          out_nxt[i] = tr_o;
          oen_nxt[i] = (ts == `PFM_TS_EVTI);
        end
        default: begin
          if (gpio_periph_en[i]) begin
            feat = is_tw(p6, fn) || is_odpwm(p6, fn);
            tw_nxt[i]  = feat;
            v5_nxt[i]  = feat && is_5v_pin(p6);
            alm_nxt[i] = feat && is_5v_pin(p6);
            if (is_odpwm(p6, fn)) begin
              out_nxt[i] = 1'b0;
              oen_nxt[i] = !(func_oe[8*i + fn] && !func_out[8*i + fn]);
            end else begin
              out_nxt[i] = func_out[8*i + fn];
              oen_nxt[i] = !func_oe[8*i + fn];
            end
          end else begin
            out_nxt[i] = gpio_out[i];
            oen_nxt[i] = !gpio_oe[i];
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registered pad and unit outputs

  wire [2:0] own_sel = own[3*pin_sel_r +: 3];
  wire       sel_ok  = (pin_sel_r < N);

  always @(posedge clock) begin
    if (!rst_n) begin
      pad_out       <= {N{1'b0}};
      pad_oe_n      <= {N{1'b1}};
      pad_analog_en <= {N{1'b0}};
      pad_tw_en     <= {N{1'b0}};
      pad_5v_en     <= {N{1'b0}};
      pad_alert_en  <= {N{1'b0}};
      pin_in        <= {N{1'b1}};
      jtag_tck      <= 1'b0;
      jtag_tms      <= 1'b1;
      jtag_tdi      <= 1'b1;
      trace_evti_n  <= 1'b1;
      link_data_in  <= 1'b1;
      rst_pad_out   <= 1'b0;
      rst_pad_oe_n  <= 1'b1;
      ext_reset_n   <= 1'b1;
      wake_req_n    <= 1'b1;
      reg_rdata     <= 32'h0000_0000;
    end else begin
      pad_out       <= out_nxt;
      pad_oe_n      <= oen_nxt;
      pad_analog_en <= ana_nxt;
      pad_tw_en     <= tw_nxt;
      pad_5v_en     <= v5_nxt;
      pad_alert_en  <= alm_nxt;
      pin_in        <= pad_sync;
      jtag_tck      <= jtag_en ? pad_sync[`PFM_PIN_TCK] : 1'b0;
      jtag_tms      <= jtag_en ? pad_sync[`PFM_PIN_TMS] : 1'b1;
      jtag_tdi      <= jtag_en ? pad_sync[`PFM_PIN_TDI] : 1'b1;
      trace_evti_n  <= trace_en ?
                       pad_sync[map_a_r ? 5 : 31] : 1'b1;
      link_data_in  <= link_en ? rst_sync : 1'b1;
      rst_pad_out   <= link_en ? link_data_out : 1'b0;
      rst_pad_oe_n  <= !(link_en && link_data_oe && !dout_act);
      ext_reset_n   <= link_en ? 1'b1 : rst_sync;
      wake_req_n    <= pad_sync[`PFM_PIN_WAKE];
      reg_rdata     <= 32'h0000_0000;
      if (reg_rd) begin
        case (reg_addr)
          `PFM_OFS_CTRL:    reg_rdata <= {31'h0, map_a_r};
          `PFM_OFS_OSC:     reg_rdata <= {29'h0, osc_r};
          `PFM_OFS_STATUS:  reg_rdata <= {27'h0, link_en, dout_act,
                                          trace_en, jtag_en, map_a_r};
          `PFM_OFS_PIN_SEL: reg_rdata <= {26'h0, pin_sel_r};
          `PFM_OFS_PIN_INFO: begin
            if (sel_ok) begin
              reg_rdata <= {25'h0, pad_alert_en[pin_sel_r],
                            pad_5v_en[pin_sel_r], pad_tw_en[pin_sel_r],
                            pad_sync[pin_sel_r], own_sel};
            end
          end
          default:          reg_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

/* verification/pfm_mux_monitor.sv */
// Purpose: port assertions for pfm_mux
// Assumes: one clock, sync active-low reset
// Notes:   up_r masks looks back into reset
`timescale 1ns/1ps
`default_nettype none
module pfm_mux_monitor #(
  parameter N = 36
) (
  input wire logic           clock,          // clock
  input wire logic           rst_n,          // reset, low
  input wire logic [N-1:0]   gpio_periph_en, // periph select
  input wire logic [3*N-1:0] gpio_func_sel,  // letters
  input wire logic [N-1:0]   gpio_out,       // gpio value
  input wire logic [8*N-1:0] func_out,       // periph values
  input wire logic           jtag_en,        // jtag on
  input wire logic           jtag_tdo,       // jtag out
  input wire logic           trace_en,       // trace on
  input wire logic           trace_evto_n,   // event out
  input wire logic           link_en,        // link on
  input wire logic           link_two_pin,   // two-pin mode
  input wire logic           link_data_out,  // link value
  input wire logic           link_data_oe,   // link drive
  input wire logic           link_data_in,   // link rx
  input wire logic           ext_reset_n,    // reset req
  input wire logic           wake_req_n,     // wake req
  input wire logic [N-1:0]   pad_in,         // pad levels
  input wire logic [N-1:0]   pad_out,        // pad values
  input wire logic [N-1:0]   pad_oe_n,       // pad drive
  input wire logic [N-1:0]   pad_analog_en,  // crystal path
  input wire logic [N-1:0]   pad_5v_en,      // 5 V feature
  input wire logic [N-1:0]   pad_alert_en    // alert feature
);
  logic [2:0] up_r;
  logic       mux30;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge clock) begin
    if (!rst_n) up_r <= 3'h0;
    else if (up_r != 3'h7) up_r <= up_r + 3'h1;
  end
  // pin 30 has no owner but the mux
  assign mux30 = gpio_periph_en[30] ? func_out[{6'h1e, gpio_func_sel[92:90]}] : gpio_out[30];
////////////////////////////////////////////////////////////////////////////////
  a_mux_pin_value: assert property (up_r != 3'h0 |-> pad_out[30] == $past(mux30))
    else $error("pin 30 value off");
  a_jtag_tdo_pin: assert property (up_r != 3'h0 && $past(jtag_en) |->
    !pad_oe_n[2] && pad_out[2] == $past(jtag_tdo)) else $error("tdo pin off");
  a_trace_event_pin: assert property (up_r != 3'h0 && $past(trace_en) |->
    !pad_oe_n[4] && pad_out[4] == $past(trace_evto_n)) else $error("event pin off");
  a_osc_no_drive: assert property (pad_analog_en[8] |-> pad_oe_n[8])
    else $error("crystal pin driven");
  a_feature_gate: assert property (pad_5v_en[21] || pad_alert_en[21] |->
    $past(gpio_periph_en[21]) && ($past(gpio_func_sel[65:63]) inside {3'h1, 3'h5}))
    else $error("pad feature without function");
  a_dout_pin: assert property (up_r != 3'h0 &&
    $past(link_en && link_two_pin && link_data_oe && !jtag_en) |->
    !pad_oe_n[0] && pad_out[0] == $past(link_data_out)) else $error("data out pin off");
  a_link_gate: assert property (up_r > 3'h3 && $past(link_en) == $past(link_en, 2) &&
    $past(link_en, 2) == $past(link_en, 3) |-> ($past(link_en) ? ext_reset_n : link_data_in))
    else $error("reset pin use off");
  a_wake_live: assert property (up_r > 3'h3 |-> wake_req_n == $past(pad_in[11], 3))
    else $error("wake request off");
endmodule
bind pfm_mux pfm_mux_monitor #(.N(N)) u_mon (.*);
`default_nettype wire

/* verification/pfm_far_model.sv */
// Purpose: pads, board levels and debugger seen from pfm_mux
// Assumes: undriven pads take the board level
// Notes:   two-pin mode only exists once the link is up
`timescale 1ns/1ps
`default_nettype none
module pfm_far_model #(
  parameter N = 36
) (
  input  wire logic [N-1:0] pad_out,      // pad value
  input  wire logic [N-1:0] pad_oe_n,     // pad drive, low
  input  wire logic [N-1:0] ext_lvl,      // board level
  output var  logic [N-1:0] pad_in,       // resolved level
  input  wire logic         rst_pad_out,  // reset pin value
  input  wire logic         rst_pad_oe_n, // reset pin drive
  input  wire logic         rst_lvl,      // board reset level
  output var  logic         rst_pad_in,   // reset pin level
  input  wire logic         link_en,      // link enabled
  input  wire logic         cmd_two_pin,  // debugger request
  output var  logic         link_two_pin  // mode seen
);
  always_comb begin
    pad_in = (pad_out & ~pad_oe_n) | (ext_lvl & pad_oe_n);
    rst_pad_in = rst_pad_oe_n ? rst_lvl : rst_pad_out;
    link_two_pin = link_en & cmd_two_pin;
  end
endmodule
`default_nettype wire

/* verification/tb.sv */
// Purpose: self-checking bench for pfm_mux
// Assumes: outputs one cycle after inputs, pad inputs three
// Notes:   pin 30 and 21 stand in for mux and feature pins
`timescale 1ns/1ps
`default_nettype none
`include "pfm_regs.vh"
module tb;
  localparam N = 36;
  logic           clock, rst_n, reg_wr, reg_rd;
  logic [7:0]     reg_addr;
  logic [31:0]    reg_wdata, reg_rdata, rd_q;
  logic [N-1:0]   gpio_periph_en, gpio_out, gpio_oe, pin_in, pad_in, pad_out, pad_oe_n;
  logic [N-1:0]   pad_analog_en, pad_tw_en, pad_5v_en, pad_alert_en, ext_lvl;
  logic [3*N-1:0] gpio_func_sel;
  logic [8*N-1:0] func_out, func_oe;
  logic [5:0]     trace_mdo;
  logic [1:0]     trace_mseo;
  logic           jtag_en, jtag_tdo, jtag_tck, jtag_tms, jtag_tdi, trace_en, trace_mcko;
  logic           trace_evto_n, trace_evti_n, link_en, link_two_pin, link_data_out;
  logic           link_data_oe, link_data_in, rst_pad_in, rst_pad_out, rst_pad_oe_n;
  logic           ext_reset_n, wake_req_n, rst_lvl, cmd_two_pin;
  int             miscompares, checks_done;
  pfm_mux #(.N(N)) uut (.*);
  pfm_far_model #(.N(N)) u_far (.*);
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    rd_q = reg_rdata;
  endtask
  task automatic complete_run;
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk(pad_oe_n, {N{1'b1}});
    chk({jtag_tck, jtag_tms, jtag_tdi, ext_reset_n, wake_req_n}, 36'h0f);
    wr(8'h20, 32'hffff_ffff);
    rd(8'h20);
    chk(rd_q, 36'h0);
    rd(`PFM_OFS_CTRL);
    chk(rd_q, 36'h0);
    rd(`PFM_OFS_OSC);
    chk(rd_q, 36'h0);
    $display("reset test done");
  endtask
  task automatic t_mux;
    for (int f = 0; f < 8; f++) begin
      @(posedge clock);
      gpio_periph_en[30] <= 1'b1;
      gpio_func_sel[92:90] <= f[2:0];
      func_out <= {{(8*N-1){1'b0}}, 1'b1} << (240 + f);
      func_oe <= {{(8*N-1){1'b0}}, 1'b1} << (240 + f);
      tick(2);
      chk({pad_out[30], pad_oe_n[30]}, 36'h2);
    end
    @(posedge clock);
    gpio_periph_en[30] <= 1'b0;
    gpio_oe[30] <= 1'b1;
    tick(5);
    chk({pad_out[30], pad_oe_n[30], pin_in[30]}, 36'h0);
    @(posedge clock);
    gpio_oe[30] <= 1'b0;
    $display("mux test done");
  endtask
  task automatic t_jtag;
    @(posedge clock);
    gpio_oe <= {N{1'b1}};
    jtag_en <= 1'b1;
    jtag_tdo <= 1'b1;
    ext_lvl[1] <= 1'b0;
    tick(5);
    chk({pad_oe_n[3:0], pad_out[2]}, 36'h17);
    chk({jtag_tck, jtag_tms, jtag_tdi}, 36'h5);
    wr(`PFM_OFS_PIN_SEL, 32'h2);
    rd(`PFM_OFS_PIN_INFO);
    chk(rd_q[2:0], `PFM_OWN_JTAG);
    @(posedge clock);
    jtag_en <= 1'b0;
    tick(1);
    chk({pad_oe_n[3:0], pad_out[2]}, 36'h0);
    @(posedge clock);
    gpio_oe <= {N{1'b0}};
    ext_lvl[1] <= 1'b1;
    $display("jtag test done");
  endtask
  task automatic t_trace;
    @(posedge clock);
    trace_en <= 1'b1;
    trace_mdo <= 6'h21;
    trace_mcko <= 1'b1;
    trace_mseo <= 2'h2;
    trace_evto_n <= 1'b0;
    ext_lvl[31] <= 1'b0;
    wr(`PFM_OFS_CTRL, 32'h1);
    tick(2);
    chk({pad_out[14], pad_out[10], pad_oe_n[14], pad_out[4], pad_oe_n[4]}, 36'h18);
    chk(pad_out[18:4], 36'h44c);
    wr(`PFM_OFS_CTRL, 32'h0);
    tick(5);
    chk({pad_out[32], pad_out[23], pad_oe_n[14], pad_out[4], trace_evti_n}, 36'h1c);
    chk(pad_out[35:23], 36'ha03);
    rd(`PFM_OFS_STATUS);
    chk(rd_q, 36'h4);
    @(posedge clock);
    trace_en <= 1'b0;
    trace_evto_n <= 1'b1;
    ext_lvl[31] <= 1'b1;
    $display("trace test done");
  endtask
  task automatic t_osc;
    logic [2:0]  sel [3] = '{3'h1, 3'h2, 3'h6};
    logic [35:0] msk [3] = '{36'h300, 36'h1400, 36'h102000};
    @(posedge clock);
    gpio_oe <= {N{1'b1}};
    for (int i = 0; i < 3; i++) begin
      wr(`PFM_OFS_OSC, {29'h0, sel[i]});
      tick(2);
      chk(pad_analog_en, msk[i]);
      chk(pad_oe_n & msk[i], msk[i]);
    end
    wr(`PFM_OFS_OSC, 32'h0);
    tick(2);
    chk(pad_analog_en, 36'h0);
    @(posedge clock);
    gpio_oe <= {N{1'b0}};
    $display("oscillator test done");
  endtask
  task automatic t_two_wire;
    for (int f = 0; f < 9; f++) begin
      @(posedge clock);
      gpio_periph_en[21] <= (f < 8);
      gpio_func_sel[65:63] <= (f < 8) ? f[2:0] : 3'h1;
      tick(2);
      chk({pad_tw_en[21], pad_5v_en[21], pad_alert_en[21]}, {3{f == 1 || f == 5}});
    end
    $display("feature test done");
  endtask
  task automatic t_link;
    @(posedge clock);
    rst_lvl <= 1'b0;
    link_data_out <= 1'b1;
    tick(5);
    chk({link_data_in, ext_reset_n, pad_oe_n[0]}, 36'h5);
    @(posedge clock);
    link_en <= 1'b1;
    tick(5);
    chk({link_data_in, ext_reset_n, pad_oe_n[0]}, 36'h3);
    @(posedge clock);
    link_data_oe <= 1'b1;
    tick(2);
    chk({pad_oe_n[0], rst_pad_oe_n, rst_pad_out}, 36'h5);
    @(posedge clock);
    jtag_en <= 1'b1;
    cmd_two_pin <= 1'b1;
    tick(2);
    chk(pad_oe_n[0], 36'h1);
    @(posedge clock);
    jtag_en <= 1'b0;
    tick(2);
    chk({pad_oe_n[0], pad_out[0], rst_pad_oe_n}, 36'h3);
    @(posedge clock);
    {link_en, cmd_two_pin, link_data_oe, link_data_out, rst_lvl} <= 5'h01;
    $display("link test done");
  endtask
  task automatic t_wake;
    @(posedge clock);
    ext_lvl[11] <= 1'b0;
    tick(5);
    chk(wake_req_n, 36'h0);
    @(posedge clock);
    ext_lvl[11] <= 1'b1;
    tick(5);
    chk(wake_req_n, 36'h1);
    $display("wake test done");
  endtask
////////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {gpio_periph_en, gpio_out, gpio_oe, gpio_func_sel, func_out, func_oe} = '0;
    {jtag_en, jtag_tdo, trace_en, trace_mdo, trace_mcko, trace_mseo} = '0;
    {link_en, link_data_out, link_data_oe, cmd_two_pin} = '0;
    {trace_evto_n, rst_lvl, ext_lvl} = '1;
    miscompares = 0;
    checks_done = 0;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    tick(1);
    t_reset();
    t_mux();
    t_jtag();
    t_trace();
    t_osc();
    t_two_wire();
    t_link();
    t_wake();
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    complete_run();
  end
endmodule
`default_nettype wire
